/* ckpc_defines.vh */
// constants for the clock divider and low-power controller
`ifndef CKPC_DEFINES_VH
`define CKPC_DEFINES_VH

// ==========================================================
// register byte offsets
`define CKPC_A_T1_CTRL       8'h00
`define CKPC_A_T2_CTRL       8'h04
`define CKPC_A_SER_CTRL      8'h08
`define CKPC_A_IRQ_EN        8'h0C
`define CKPC_A_STATUS        8'h10

// ==========================================================
// field positions
`define CKPC_B_T1_MODE       5
`define CKPC_B_T2_STOP       5
`define CKPC_B_SER_STOP      7
`define CKPC_B_OSC_RUN       8
`define CKPC_B_IRQ_LO        16

// ==========================================================
// reset values
`define CKPC_RV_CTRL         8'h00
`define CKPC_RV_IRQ_EN       3'b000

// ==========================================================
// timing
`define CKPC_CLK_MHZ         50
`define CKPC_OSC_STAB_MS     10
`define CKPC_STATE_DIV       2
`define CKPC_STAB_W          20

// ==========================================================
// bus encodings
`define CKPC_HTRANS_NONSEQ   2'b10
`define CKPC_HRESP_OKAY      1'b0

`endif

/* ckpc_sync.v */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module ckpc_sync #(
    parameter W = 4
) (
    input  wire         clk,
    input  wire         resetn,
    input  wire [W-1:0] pin_in,
    output wire [W-1:0] pin_sync
);

    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    reg [W-1:0] out_r;

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            always @(posedge clk) begin
                if (!resetn) begin
                    s1_r[g]  <= 1'b0;
                    s2_r[g]  <= 1'b0;
                    s3_r[g]  <= 1'b0;
                    out_r[g] <= 1'b0;
                end else begin
                    s1_r[g] <= pin_in[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    // a change counts only once stages two and three agree
                    if (s2_r[g] == s3_r[g]) begin
                        out_r[g] <= s3_r[g];
                    end
                end
            end
        end
    endgenerate

    assign pin_sync = out_r;

endmodule // ckpc_sync

/* ckpc_top.v */
// clock divider and low-power mode controller with ahb-lite registers
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "ckpc_defines.vh"

module ckpc_top #(
    parameter VARIANT_TWO = 0,
    parameter OSC_OFF     = 0,
    parameter RC_SOURCE   = 0,
    parameter STAB_CYCLES = `CKPC_OSC_STAB_MS * `CKPC_CLK_MHZ * 1000
) (
    input  wire        clk,
    input  wire        resetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire        osc_input_pin,
    output wire        osc_drive_pin,
    input  wire        irq_source_a,
    input  wire        irq_source_b,
    input  wire        irq_source_c,
    input  wire        idle_exec,
    input  wire [31:0] port_data_in,
    input  wire [31:0] port_dir_in,
    output wire [31:0] port_data_out,
    output wire [31:0] port_dir_out,
    output wire        cpu_clk_en,
    output wire        tmr1_clk_en,
    output wire        tmr2_clk_en,
    output wire        ser_clk_en,
    output wire        ram_hold,
    output wire        wake_pulse
);

    // ==========================================================
    // state encoding
    localparam [4:0] ST_RUN    = 5'b00001;
    localparam [4:0] ST_WAKE   = 5'b00010;
    localparam [4:0] ST_HALT   = 5'b00100;
    localparam [4:0] ST_STAB   = 5'b01000;
    localparam [4:0] ST_RESUME = 5'b10000;

    // crystal start-up wait only exists for the oscillator-off build
    localparam NEED_STAB = (OSC_OFF != 0) && (RC_SOURCE == 0);
    localparam [4:0] ST_BOOT = NEED_STAB ? ST_STAB : ST_RUN;
    localparam [31:0]             STAB_FULL = STAB_CYCLES - 1;
    localparam [`CKPC_STAB_W-1:0] STAB_LAST = STAB_FULL[`CKPC_STAB_W-1:0];

    // ==========================================================
    // declarations
    reg  [4:0]              state_r;
    reg  [4:0]              state_nxt;
    reg  [`CKPC_STAB_W-1:0] stab_cnt_r;
    reg  [7:0]              t1_ctrl_r;
    reg  [7:0]              t2_ctrl_r;
    reg  [7:0]              ser_ctrl_r;
    reg  [2:0]              irq_en_r;
    reg                     wr_pend_r;
    reg  [7:0]              wr_addr_r;
    reg  [31:0]             hrdata_r;
    reg                     hreadyout_r;
    reg                     hresp_r;
    reg                     osc_prev_r;
    reg                     phase_r;
    reg                     tick_r;
    reg                     osc_en_r;
    reg  [31:0]             port_data_r;
    reg  [31:0]             port_dir_r;
    reg                     cpu_en_r;
    reg                     tmr1_en_r;
    reg                     tmr2_en_r;
    reg                     ser_en_r;
    reg                     ram_hold_r;
    reg                     wake_r;
    wire [3:0]              pins_sync;
    wire                    osc_sync;
    wire [2:0]              irq_sync;
    wire [2:0]              irq_live;
    wire                    bus_req;
    wire                    wake_hit;
    wire                    halt_hit;
    wire                    sleeping;
    wire                    t1_on;
    wire                    t2_on;
    wire                    ser_on;

    // ==========================================================
    // address decode helper
    function hit;
        input [31:0] a;
        input [7:0]  off;
        begin
            hit = (a[31:8] == 24'h00_0000) && (a[7:0] == off);
        end
    endfunction

    // ==========================================================
    // pin synchronisers
    ckpc_sync #(
        .W (4)
    ) u_sync (
        .clk      (clk),
        .resetn   (resetn),
        .pin_in   ({irq_source_c, irq_source_b, irq_source_a, osc_input_pin}),
        .pin_sync (pins_sync)
    );

    assign osc_sync = pins_sync[0];
    assign irq_sync = pins_sync[3:1];
    assign irq_live = irq_sync & irq_en_r;

    // ==========================================================
    // ahb-lite slave, zero wait states, always okay
    assign bus_req = hsel & hready & (htrans == `CKPC_HTRANS_NONSEQ);

    always @(posedge clk) begin
        if (!resetn) begin
            wr_pend_r   <= 1'b0;
            wr_addr_r   <= 8'h00;
            hreadyout_r <= 1'b1;
            hresp_r     <= `CKPC_HRESP_OKAY;
        end else begin
            wr_pend_r   <= bus_req & hwrite & (haddr[31:8] == 24'h00_0000);
            wr_addr_r   <= haddr[7:0];
            hreadyout_r <= 1'b1;
            hresp_r     <= `CKPC_HRESP_OKAY;
        end
    end

    // oscillator option has no register: it cannot be changed at run time
    always @(posedge clk) begin
        if (!resetn) begin
            t1_ctrl_r  <= `CKPC_RV_CTRL;
            t2_ctrl_r  <= `CKPC_RV_CTRL;
            ser_ctrl_r <= `CKPC_RV_CTRL;
            irq_en_r   <= `CKPC_RV_IRQ_EN;
        end else if (wr_pend_r) begin
            if (wr_addr_r == `CKPC_A_T1_CTRL) begin
                t1_ctrl_r <= hwdata[7:0];
            end else if (wr_addr_r == `CKPC_A_T2_CTRL) begin
                t2_ctrl_r <= hwdata[7:0];
            end else if (wr_addr_r == `CKPC_A_SER_CTRL) begin
                ser_ctrl_r <= hwdata[7:0];
            end else if (wr_addr_r == `CKPC_A_IRQ_EN) begin
                irq_en_r <= hwdata[2:0];
            end
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (bus_req & ~hwrite) begin
            if (hit(haddr, `CKPC_A_T1_CTRL)) begin
                hrdata_r <= {24'h00_0000, t1_ctrl_r};
            end else if (hit(haddr, `CKPC_A_T2_CTRL)) begin
                hrdata_r <= {24'h00_0000, t2_ctrl_r};
            end else if (hit(haddr, `CKPC_A_SER_CTRL)) begin
                hrdata_r <= {24'h00_0000, ser_ctrl_r};
            end else if (hit(haddr, `CKPC_A_IRQ_EN)) begin
                hrdata_r <= {29'h0000_0000, irq_en_r};
            end else if (hit(haddr, `CKPC_A_STATUS)) begin
                hrdata_r <= {13'h0000, irq_sync, 7'h00, osc_en_r, 3'h0, state_r};
            end else begin
                hrdata_r <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // state clock: one tick on every second oscillator rising edge
    always @(posedge clk) begin
        if (!resetn) begin
            osc_prev_r <= 1'b0;
            phase_r    <= 1'b0;
            tick_r     <= 1'b0;
        end else begin
            osc_prev_r <= osc_sync;
            tick_r     <= 1'b0;
            if (osc_sync & ~osc_prev_r & osc_en_r) begin
                phase_r <= ~phase_r;
                tick_r  <= phase_r;
            end
        end
    end

    // ==========================================================
    // exit conditions per mode
    // halt listens to sources a and b only, wake-up to all three
    assign halt_hit = |irq_live[1:0];
    assign wake_hit = |irq_live;

    // ==========================================================
    // low-power state machine
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (idle_exec) begin
                    if ((VARIANT_TWO == 0) && t1_ctrl_r[`CKPC_B_T1_MODE]) begin
                        state_nxt = ST_HALT;
                    end else begin
                        state_nxt = ST_WAKE;
                    end
                end
            end
            ST_WAKE: begin
                if (wake_hit) begin
                    state_nxt = ST_RESUME;
                end
            end
            ST_HALT: begin
                if (halt_hit) begin
                    if (NEED_STAB) begin
                        state_nxt = ST_STAB;
                    end else begin
                        state_nxt = ST_RESUME;
                    end
                end
            end
            ST_STAB: begin
                if (stab_cnt_r == STAB_LAST) begin
                    state_nxt = ST_RESUME;
                end
            end
            ST_RESUME: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // reset always lands in the stabilising wait in the oscillator-off crystal build, from any state
    always @(posedge clk) begin
        if (!resetn) begin
            state_r <= ST_BOOT;
        end else begin
            state_r <= state_nxt;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            stab_cnt_r <= {`CKPC_STAB_W{1'b0}};
        end else if (state_r == ST_STAB) begin
            stab_cnt_r <= stab_cnt_r + 1'b1;
        end else begin
            stab_cnt_r <= {`CKPC_STAB_W{1'b0}};
        end
    end

    // ==========================================================
    // clock gating decisions
    assign sleeping = (state_r == ST_WAKE) | (state_r == ST_HALT);

    // timers keep running in wake-up unless variant two sets their mode or stop bit, so a timer interrupt can end it
    assign t1_on = (state_r == ST_HALT) ? 1'b0 :
                   ((VARIANT_TWO != 0) && (state_r == ST_WAKE)) ?
                   ~t1_ctrl_r[`CKPC_B_T1_MODE] : 1'b1;
    assign t2_on = (state_r == ST_HALT) ? 1'b0 :
                   ((VARIANT_TWO != 0) && (state_r == ST_WAKE)) ?
                   ~t2_ctrl_r[`CKPC_B_T2_STOP] : 1'b1;
    assign ser_on = (state_r == ST_HALT) ? 1'b0 :
                    ((VARIANT_TWO != 0) && (state_r == ST_WAKE)) ?
                    ~ser_ctrl_r[`CKPC_B_SER_STOP] : 1'b1;

    always @(posedge clk) begin
        if (!resetn) begin
            osc_en_r <= 1'b1;
        end else if ((OSC_OFF != 0) && (state_nxt == ST_HALT)) begin
            osc_en_r <= 1'b0;
        end else begin
            osc_en_r <= 1'b1;
        end
    end

    // stab and resume restart the peripherals before the cpu clock
    always @(posedge clk) begin
        if (!resetn) begin
            cpu_en_r  <= 1'b0;
            tmr1_en_r <= 1'b0;
            tmr2_en_r <= 1'b0;
            ser_en_r  <= 1'b0;
        end else begin
            // no cpu tick in the cycle that takes the sleep, so hold and tick never overlap
            cpu_en_r  <= tick_r & (state_r == ST_RUN) & (state_nxt == ST_RUN);
            tmr1_en_r <= tick_r & t1_on;
            tmr2_en_r <= tick_r & t2_on;
            ser_en_r  <= tick_r & ser_on;
        end
    end

    // ==========================================================
    // port freeze and ram protection
    // ports follow the cpu only while running, so the value seen
    // in the sleep cycle itself is the one held
    always @(posedge clk) begin
        if (!resetn) begin
            port_data_r <= 32'hFFFF_FFFF;
            port_dir_r  <= 32'h0000_0000;
        end else if (state_r == ST_RUN) begin
            port_data_r <= port_data_in;
            port_dir_r  <= port_dir_in;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            ram_hold_r <= 1'b0;
        end else begin
            ram_hold_r <= (state_nxt != ST_RUN);
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= sleeping & (state_nxt != state_r);
        end
    end

    // ==========================================================
    // outputs
    assign hrdata        = hrdata_r;
    assign hreadyout     = hreadyout_r;
    assign hresp         = hresp_r;
    assign osc_drive_pin = osc_en_r;
    assign port_data_out = port_data_r;
    assign port_dir_out  = port_dir_r;
    assign cpu_clk_en    = cpu_en_r;
    assign tmr1_clk_en   = tmr1_en_r;
    assign tmr2_clk_en   = tmr2_en_r;
    assign ser_clk_en    = ser_en_r;
    assign ram_hold      = ram_hold_r;
    assign wake_pulse    = wake_r;

endmodule // ckpc_top

/* ckpc_props.sv */
// concurrent checks for the clock divider and low-power controller
`timescale 1ns/1ps

module ckpc_props (
    input logic        clk,
    input logic        resetn,
    input logic        idle_exec,
    input logic [31:0] port_data_in,
    input logic [31:0] port_dir_in,
    input logic [31:0] port_data_out,
    input logic [31:0] port_dir_out,
    input logic        cpu_clk_en,
    input logic        tmr1_clk_en,
    input logic        osc_drive_pin,
    input logic        ram_hold,
    input logic        wake_pulse
);
    logic slp_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ==========================================================
    // sleep tracker
    // ports only count as frozen from a taken sleep until the hold drops;
    // the start-up wait after reset also raises the hold but freezes nothing
    always_ff @(posedge clk) begin
        if (!resetn)
            slp_r <= 1'b0;
        else if (idle_exec && !ram_hold)
            slp_r <= 1'b1;
        else if ($fell(ram_hold))
            slp_r <= 1'b0;
    end

    // ==========================================================
    // properties
    a_sleep_takes_hold: assert property (idle_exec && !ram_hold |-> ##2 ram_hold)
        else $error("hold not raised after sleep");
    a_freeze_value: assert property (idle_exec && !ram_hold |-> ##2
        (port_data_out == $past(port_data_in, 2) && port_dir_out == $past(port_dir_in, 2)))
        else $error("ports not frozen to sleep-cycle values");
    a_freeze_hold: assert property (slp_r && ram_hold && $past(ram_hold) |->
        $stable(port_data_out) && $stable(port_dir_out))
        else $error("ports moved while asleep");
    a_cpu_gated: assert property (ram_hold |-> !cpu_clk_en)
        else $error("cpu ticked while held");
    a_halt_stops: assert property (!osc_drive_pin && !$past(osc_drive_pin) |-> !cpu_clk_en && !tmr1_clk_en)
        else $error("cpu or timer ticked in halt");
    a_osc_off_sleep: assert property (!osc_drive_pin && !$past(osc_drive_pin) |-> ram_hold)
        else $error("oscillator off outside low power");
    a_wake_resumes: assert property (wake_pulse |-> ##[0:40] !ram_hold)
        else $error("no resume after wake");
    a_wake_single: assert property (wake_pulse |=> !wake_pulse)
        else $error("wake pulse longer than one cycle");
    a_tick_gap: assert property (cpu_clk_en |=> !cpu_clk_en [*3])
        else $error("state ticks too close");

    c_sleep: cover property (idle_exec && !ram_hold);
    c_wake: cover property (wake_pulse);
    c_osc_off: cover property (!osc_drive_pin);
endmodule // ckpc_props

bind ckpc_top ckpc_props u_props (.clk, .resetn, .idle_exec, .port_data_in, .port_dir_in, .port_data_out,
    .port_dir_out, .cpu_clk_en, .tmr1_clk_en, .osc_drive_pin, .ram_hold, .wake_pulse);

/* testbench.sv */
// self-checking bench for the clock divider and low-power controller
`timescale 1ns/1ps

module testbench;
    localparam int          STAB = 20;
    localparam logic [31:0] ADR_T1 = 32'h0;
    localparam logic [31:0] ADR_IE = 32'hC;
    localparam logic [31:0] ADR_ST = 32'h10;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        idle_exec = 1'b0;
    logic        osc_input_pin = 1'b0;
    logic        irq_source_a = 1'b0;
    logic        irq_source_b = 1'b0;
    logic        irq_source_c = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  osc_cnt = 3'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] port_data_in = 32'h0;
    logic [31:0] port_dir_in = 32'h0;
    logic [31:0] hrdata, port_data_out, port_dir_out;
    logic        hreadyout, hresp, osc_drive_pin, cpu_clk_en, tmr1_clk_en;
    logic        tmr2_clk_en, ser_clk_en, ram_hold, wake_pulse;
    logic        osc_input_pin_2 = 1'b0;
    logic [31:0] port_data_out_2;
    logic        osc_drive_pin_2, tmr1_clk_en_2, tmr2_clk_en_2, ser_clk_en_2, ram_hold_2;
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc = 0;
    int          n1, n2;

    ckpc_top #(.VARIANT_TWO(0), .OSC_OFF(1), .RC_SOURCE(0), .STAB_CYCLES(STAB)) u_ckpc_top (
        .clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .osc_input_pin, .osc_drive_pin, .irq_source_a, .irq_source_b,
        .irq_source_c, .idle_exec, .port_data_in, .port_dir_in, .port_data_out, .port_dir_out,
        .cpu_clk_en, .tmr1_clk_en, .tmr2_clk_en, .ser_clk_en, .ram_hold, .wake_pulse
    );

    // second build: variant two, oscillator kept in halt; shares bus, sleep and irq pins
    ckpc_top #(.VARIANT_TWO(1), .OSC_OFF(0), .RC_SOURCE(0), .STAB_CYCLES(STAB)) u_ckpc_top_2 (
        .clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata(), .hreadyout(), .hresp(), .osc_input_pin(osc_input_pin_2),
        .osc_drive_pin(osc_drive_pin_2), .irq_source_a, .irq_source_b, .irq_source_c, .idle_exec,
        .port_data_in, .port_dir_in, .port_data_out(port_data_out_2), .port_dir_out(), .cpu_clk_en(),
        .tmr1_clk_en(tmr1_clk_en_2), .tmr2_clk_en(tmr2_clk_en_2), .ser_clk_en(ser_clk_en_2),
        .ram_hold(ram_hold_2), .wake_pulse()
    );

    // ==========================================================
    // clock, oscillator pin at one eighth of clk, hang guard
    always #10 clk = ~clk;

    // a crystal stops when its drive is off, so the pin goes quiet too
    always @(posedge clk) begin
        osc_cnt <= osc_cnt + 3'h1;
        osc_input_pin <= osc_drive_pin & osc_cnt[2];
        osc_input_pin_2 <= osc_drive_pin_2 & osc_cnt[2];
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic close_out();
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [31:0] a, exp, msk);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q & msk, exp);
    endtask

    // which: 0 wake pulse, 1 timer tick, 2 cpu tick
    task automatic wait_for(input int which, input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            if ((which == 0 && wake_pulse === 1'b1) || (which == 1 && tmr1_clk_en === 1'b1)
                || (which == 2 && cpu_clk_en === 1'b1)) break;
        end
        chk(n < lim, 32'h1);
    endtask

    // one bit per peripheral enable of both builds that pulsed within 32 cycles
    task automatic seen_en(output logic [5:0] m);
        m = 6'h0;
        repeat (32) begin
            @(posedge clk);
            m = m | {tmr1_clk_en, tmr2_clk_en, ser_clk_en, tmr1_clk_en_2, tmr2_clk_en_2, ser_clk_en_2};
        end
    endtask

    task automatic sleep(input logic [31:0] d);
        port_data_in <= d;
        port_dir_in <= ~d;
        idle_exec <= 1'b1;
        @(posedge clk);
        idle_exec <= 1'b0;
        port_data_in <= ~d;
        port_dir_in <= d;
        repeat (3) @(posedge clk);
        chk(port_data_out, d);
        chk(port_dir_out, ~d);
        chk(ram_hold, 32'h1);
        chk(port_data_out_2, d);
        chk(ram_hold_2, 32'h1);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs();
        for (int i = 0; i < 4; i++) begin
            wr(4 * i, ALL);
            rd(4 * i, (i == 3) ? 32'h7 : 32'hFF, ALL);
            wr(4 * i, 32'h0);
        end
        wr(32'h14, ALL);
        rd(32'h14, 32'h0, ALL);
        wr(ADR_ST, 32'h0);
        rd(ADR_ST, 32'h101, 32'h11F);
    endtask

    task automatic t_clock();
        wait_for(2, 40, n1);
        wait_for(2, 40, n1);
        chk(n1, 15);
    endtask

    task automatic t_wake();
        logic [5:0] m;
        wr(ADR_T1, 32'h0);
        wr(ADR_IE, 32'h4);
        sleep(32'hA5A5_0F0F);
        rd(ADR_ST, 32'h2, 32'h1F);
        wait_for(1, 40, n1);
        seen_en(m);
        chk(m, 32'h3F);
        irq_source_a <= 1'b1;
        repeat (10) @(posedge clk);
        rd(ADR_ST, 32'h2, 32'h1F);
        irq_source_c <= 1'b1;
        wait_for(0, 40, n1);
        wait_for(2, 40, n1);
        repeat (2) @(posedge clk);
        chk(port_data_out, 32'h5A5A_F0F0);
        rd(ADR_ST, 32'h1, 32'h1F);
        irq_source_a <= 1'b0;
        irq_source_c <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    task automatic t_halt();
        logic [5:0] m;
        wr(ADR_T1, 32'h20);
        wr(32'h4, 32'h20);
        wr(32'h8, 32'h80);
        wr(ADR_IE, 32'h7);
        sleep(32'h1234_5678);
        rd(ADR_ST, 32'h4, 32'h1F);
        chk(osc_drive_pin, 32'h0);
        seen_en(m);
        chk(m, 32'h0);
        irq_source_c <= 1'b1;
        repeat (10) @(posedge clk);
        rd(ADR_ST, 32'h4, 32'h1F);
        chk(ram_hold_2, 32'h0);
        irq_source_b <= 1'b1;
        wait_for(0, 80, n1);
        wait_for(2, 80, n2);
        chk(n1 + n2 >= STAB, 32'h1);
        chk(osc_drive_pin, 32'h1);
        irq_source_b <= 1'b0;
        irq_source_c <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    task automatic t_reset_exit();
        wr(ADR_T1, 32'h0);
        sleep(32'h0F0F_0F0F);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(ADR_ST, 32'h8, 32'h1F);
        chk(port_data_out, ALL);
        chk(ram_hold_2, 32'h0);
        repeat (STAB) @(posedge clk);
        rd(ADR_ST, 32'h1, 32'h1F);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        chk(port_data_out, ALL);
        chk(port_dir_out, 32'h0);
        chk(hreadyout, 32'h1);
        chk(hresp, 32'h0);
        resetn <= 1'b1;
        @(posedge clk);
        rd(ADR_ST, 32'h8, 32'h1F);
        repeat (STAB) @(posedge clk);
        t_regs();
        t_clock();
        t_wake();
        t_halt();
        t_reset_exit();
        close_out();
    end
endmodule // testbench
